// File: logic/gsr_map.svh
`ifndef GSR_MAP_SVH
`define GSR_MAP_SVH

// Register offsets on the management port
`define GSR_OFS_PIN_STATUS    8'h25
`define GSR_OFS_BATTERY       8'h26
`define GSR_OFS_AIN_EIGHT     8'h27
`define GSR_OFS_REMOTE_ONE    8'h28
`define GSR_OFS_REMOTE_TWO    8'h29
`define GSR_OFS_STANDBY_RAIL  8'h2A
`define GSR_OFS_MAIN_RAIL     8'h2B
`define GSR_OFS_PLUS_FIVE     8'h2C
`define GSR_OFS_CORE_VOLTAGE  8'h2D
`define GSR_OFS_PLUS_TWELVE   8'h2E
`define GSR_OFS_MINUS_TWELVE  8'h2F
`define GSR_OFS_AIN_ZERO      8'h30

// Span of the reading registers
`define GSR_OFS_FIRST_READING 8'h26
`define GSR_OFS_LAST_READING  8'h30
`define GSR_NUM_READINGS      11

// Reset values and the read value of unmapped offsets
`define GSR_RST_PIN_STATUS    8'h00
`define GSR_RST_READING       8'h00
`define GSR_UNMAPPED_DATA     8'h00

// Polarity bit positions inside a pin configuration register
`define GSR_POL_BIT_A         1
`define GSR_POL_BIT_B         3
`define GSR_POL_BIT_C         5
`define GSR_POL_BIT_D         7

`endif

// File: logic/gsr_pkg.sv
package gsr_pkg;

    // One register byte
    typedef logic [7:0] gsr_byte_t;

    // Conversion channel codes from the measurement engine
    typedef enum logic [3:0] {
        gsr_ch_battery      = 4'h0,
        gsr_ch_ain_eight    = 4'h1,
        gsr_ch_remote_one   = 4'h2,
        gsr_ch_remote_two   = 4'h3,
        gsr_ch_ain_nine     = 4'h4,
        gsr_ch_standby_rail = 4'h5,
        gsr_ch_main_rail    = 4'h6,
        gsr_ch_plus_five    = 4'h7,
        gsr_ch_core_voltage = 4'h8,
        gsr_ch_plus_twelve  = 4'h9,
        gsr_ch_minus_twelve = 4'hA,
        gsr_ch_ain_zero     = 4'hB
    } gsr_chan_t;

endpackage

// File: logic/gsr_pin_if.sv
`timescale 1ns/10ps

// Link between the register front end and the pin bank
interface gsr_pin_if;
    gsr_pkg::gsr_byte_t wr_data;  // Host write data
    logic               wr_en;    // Write to the pin status register
    gsr_pkg::gsr_byte_t dir_out;  // Per pin, 1 = output
    gsr_pkg::gsr_byte_t act_high; // Per pin, 1 = asserted when high
    gsr_pkg::gsr_byte_t status;   // Pin status bits

    modport regs (output wr_data, wr_en, dir_out, act_high,
                  input  status);
    modport bank (input  wr_data, wr_en, dir_out, act_high,
                  output status);
endinterface

// File: logic/gsr_pin_bank.sv
`timescale 1ns/10ps

`include "gsr_map.svh"

// Status bits and pad drive for the upper eight general pins
module gsr_pin_bank (
    input  wire logic       clk,
    input  wire logic       resetn,
    gsr_pin_if.bank         pif,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe
);

    logic [7:0] meta_r;      // First synchroniser stage
    logic [7:0] sync_r;      // Second synchroniser stage
    logic [7:0] asserted;    // Pin at its asserted level
    logic [7:0] status_r;    // Status bits
    logic [7:0] status_nxt;  // Next status bits
    logic [7:0] pin_out_r;   // Registered pad level
    logic [7:0] pin_oe_r;    // Registered pad enable

    // Pads are asynchronous, two stages before any use; no reset here
    // so the stages hold the real pad level when reset lifts, and an
    // idle active-low input never reads as asserted for a cycle
    always_ff @(posedge clk) begin
        meta_r <= pin_in;
        sync_r <= meta_r;
    end

    // Level match against the selected polarity
    assign asserted = ~(sync_r ^ pif.act_high);

    // Inputs mirror the pad; outputs keep what the host wrote
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pif.dir_out[i]) begin
                status_nxt[i] = asserted[i];
            end else if (pif.wr_en) begin
                status_nxt[i] = pif.wr_data[i];
            end else begin
                status_nxt[i] = status_r[i];
            end
        end
    end

    // Status register, cleared at reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_r <= `GSR_RST_PIN_STATUS;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Pad drive: asserted level when the bit is set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_out_r <= 8'h00;
            pin_oe_r  <= 8'h00;
        end else begin
            pin_out_r <= ~(status_r ^ pif.act_high);
            pin_oe_r  <= pif.dir_out;
        end
    end

    assign pif.status = status_r;
    assign pin_out    = pin_out_r;
    assign pin_oe     = pin_oe_r;

endmodule

// File: logic/gsr_reading_regs.sv
`timescale 1ns/10ps

`include "gsr_map.svh"

// Pin status and measured reading register bank
module gsr_reading_regs (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rd_data,
    output logic            reg_rd_valid,
    input  wire logic [7:0] pin_dir_out,
    input  wire logic [7:0] pin_cfg_three,
    input  wire logic [7:0] pin_cfg_four,
    input  wire logic       remote_two_mode,
    input  wire logic       conv_valid,
    input  wire logic [3:0] conv_chan,
    input  wire logic [7:0] conv_data,
    input  wire logic [7:0] general_io_pin_in,
    output logic      [7:0] general_io_pin_out,
    output logic      [7:0] general_io_pin_oe
);

    localparam int NUM_RD = `GSR_NUM_READINGS; // Reading slots

    gsr_pin_if pif ();              // Link to the pin bank

    gsr_pkg::gsr_chan_t chan;       // Typed channel code
    gsr_pkg::gsr_byte_t rd_r [0:NUM_RD-1]; // Reading storage
    logic [3:0]         conv_slot;  // Slot the result lands in
    logic               conv_live;  // Result is accepted
    logic               hit_status; // Access to the status reg
    gsr_pkg::gsr_byte_t rd_data_r;  // Registered read data
    logic               rd_valid_r; // Read answer strobe
    gsr_pkg::gsr_byte_t rd_mux;     // Read selection
    logic               rd_all_zero; // Every reading slot cleared

    // Polarity bits of one config register, lowest pin first
    function automatic logic [3:0] pol_nibble(input logic [7:0] cfg);
        pol_nibble = {cfg[`GSR_POL_BIT_D], cfg[`GSR_POL_BIT_C],
                      cfg[`GSR_POL_BIT_B], cfg[`GSR_POL_BIT_A]};
    endfunction

    // Register offset for a conversion channel
    function automatic logic [7:0] chan_offset(
        input gsr_pkg::gsr_chan_t ch
    );
        case (ch)
            gsr_pkg::gsr_ch_battery:
                chan_offset = `GSR_OFS_BATTERY;
            gsr_pkg::gsr_ch_ain_eight:
                chan_offset = `GSR_OFS_AIN_EIGHT;
            gsr_pkg::gsr_ch_remote_one:
                chan_offset = `GSR_OFS_REMOTE_ONE;
            gsr_pkg::gsr_ch_remote_two:
                chan_offset = `GSR_OFS_REMOTE_TWO;
            gsr_pkg::gsr_ch_ain_nine:
                chan_offset = `GSR_OFS_REMOTE_TWO;
            gsr_pkg::gsr_ch_standby_rail:
                chan_offset = `GSR_OFS_STANDBY_RAIL;
            gsr_pkg::gsr_ch_main_rail:
                chan_offset = `GSR_OFS_MAIN_RAIL;
            gsr_pkg::gsr_ch_plus_five:
                chan_offset = `GSR_OFS_PLUS_FIVE;
            gsr_pkg::gsr_ch_core_voltage:
                chan_offset = `GSR_OFS_CORE_VOLTAGE;
            gsr_pkg::gsr_ch_plus_twelve:
                chan_offset = `GSR_OFS_PLUS_TWELVE;
            gsr_pkg::gsr_ch_minus_twelve:
                chan_offset = `GSR_OFS_MINUS_TWELVE;
            gsr_pkg::gsr_ch_ain_zero:
                chan_offset = `GSR_OFS_AIN_ZERO;
            default:
                chan_offset = `GSR_OFS_BATTERY;
        endcase
    endfunction

    // Storage slot for a reading offset
    function automatic logic [3:0] slot_of(input logic [7:0] ofs);
        logic [7:0] diff;
        diff = ofs - `GSR_OFS_FIRST_READING;
        slot_of = diff[3:0];
    endfunction

    // Offset falls inside the reading window
    function automatic logic is_reading(input logic [7:0] ofs);
        is_reading = (ofs >= `GSR_OFS_FIRST_READING) &&
                     (ofs <= `GSR_OFS_LAST_READING);
    endfunction

    // Channel codes above the last one are dropped
    assign chan = gsr_pkg::gsr_chan_t'(conv_chan);

    // Shared slot 3 (offset 29h) follows the configured channel function
    always_comb begin
        case (chan)
            gsr_pkg::gsr_ch_remote_two:
                conv_live = conv_valid && remote_two_mode;
            gsr_pkg::gsr_ch_ain_nine:
                conv_live = conv_valid && !remote_two_mode;
            default:
                conv_live = conv_valid &&
                            (conv_chan <= 4'hB);
        endcase
    end

    assign conv_slot = slot_of(chan_offset(chan));

    // Config feeds to the pin bank
    assign pif.dir_out  = pin_dir_out;
    assign pif.act_high = {pol_nibble(pin_cfg_four),
                           pol_nibble(pin_cfg_three)};

    // Host write to the status register
    assign hit_status  = (reg_addr == `GSR_OFS_PIN_STATUS);
    assign pif.wr_en   = reg_wr_en && hit_status;
    assign pif.wr_data = reg_wr_data;

    // Pin bank holds status bits and drives the pads
    gsr_pin_bank gsr_pin_bank_i (
        .clk     (clk),
        .resetn  (resetn),
        .pif     (pif.bank),
        .pin_in  (general_io_pin_in),
        .pin_out (general_io_pin_out),
        .pin_oe  (general_io_pin_oe)
    );

    // Reading store; the host has no write path here at all
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_RD; i++) begin
                rd_r[i] <= `GSR_RST_READING;
            end
        end else if (conv_live) begin
            rd_r[conv_slot] <= conv_data;
        end
    end

    // Read selection; unmapped offsets answer zero
    always_comb begin
        if (hit_status) begin
            rd_mux = pif.status;
        end else if (is_reading(reg_addr)) begin
            rd_mux = rd_r[slot_of(reg_addr)];
        end else begin
            rd_mux = `GSR_UNMAPPED_DATA;
        end
    end

    // Read data is captured one edge after the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_data_r <= 8'h00;
        end else if (reg_rd_en) begin
            rd_data_r <= rd_mux;
        end
    end

    // One-cycle answer strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
        end
    end

    assign reg_rd_data  = rd_data_r;
    assign reg_rd_valid = rd_valid_r;

    // Checks, all on the one clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Host read of the status register
    sequence s_status_read;
        reg_rd_en && hit_status;
    endsequence

    // Host write of the status register
    sequence s_status_write;
        reg_wr_en && hit_status;
    endsequence

    // Battery result followed by a read of its offset
    sequence s_battery_then_read;
        conv_valid && chan == gsr_pkg::gsr_ch_battery
        ##1 reg_rd_en && reg_addr == `GSR_OFS_BATTERY;
    endsequence

    // Negative rail result followed by a read of its offset
    sequence s_minus_then_read;
        conv_valid && chan == gsr_pkg::gsr_ch_minus_twelve
        ##1 reg_rd_en && reg_addr == `GSR_OFS_MINUS_TWELVE;
    endsequence

    // Pin 8 held as a quiet input for three cycles
    sequence s_pin0_quiet;
        (!pin_dir_out[0] && $stable(general_io_pin_in[0]) &&
         $stable(pin_cfg_three[1]))[*3];
    endsequence

    // Pin 9 held as a quiet input for three cycles
    sequence s_pin1_quiet;
        (!pin_dir_out[1] && $stable(general_io_pin_in[1]) &&
         $stable(pin_cfg_three[3]))[*3];
    endsequence

    // Analog input nine result on the shared slot
    sequence s_nine_result;
        conv_valid && chan == gsr_pkg::gsr_ch_ain_nine;
    endsequence

    // All reading slots at their reset value, for the reset check
    always_comb begin
        rd_all_zero = 1'b1;
        for (int i = 0; i < NUM_RD; i++) begin
            if (rd_r[i] != `GSR_RST_READING) begin
                rd_all_zero = 1'b0;
            end
        end
    end

    AST_STATUS_READ: assert property (
        s_status_read |=> reg_rd_valid &&
                          reg_rd_data == $past(pif.status))
        else $error("status read returned wrong data");

    AST_IN_FOLLOW: assert property (
        s_pin0_quiet |-> pif.status[0] ==
            ~(general_io_pin_in[0] ^ pin_cfg_three[1]))
        else $error("input status bit does not follow pin");

    AST_OUT_WRITE: assert property (
        s_status_write ##0 pin_dir_out != 8'h00
        |=> ((pif.status ^ $past(reg_wr_data)) & $past(pin_dir_out))
            == 8'h00 ##1
            general_io_pin_out ==
            ~($past(pif.status) ^ $past(pif.act_high)))
        else $error("output pin not driven from written bit");

    AST_POL_THREE: assert property (
        pin_dir_out[0] && pif.status[0]
        |=> general_io_pin_out[0] == $past(pin_cfg_three[1]))
        else $error("pin 8 polarity not from config three");

    AST_POL_FOUR: assert property (
        pin_dir_out[4] && pif.status[4]
        |=> general_io_pin_out[4] == $past(pin_cfg_four[1]))
        else $error("pin 12 polarity not from config four");

    AST_IN_WRITE_IGNORED: assert property (
        s_pin1_quiet ##0 s_status_write
        |=> pif.status[1] == $past(pif.status[1]))
        else $error("write landed on an input status bit");

    AST_RO_WRITE: assert property (
        reg_wr_en && reg_addr == `GSR_OFS_MINUS_TWELVE && !conv_valid
        |=> rd_r[9] == $past(rd_r[9]))
        else $error("host write changed a reading");

    AST_BATTERY_SLOT: assert property (
        s_battery_then_read |=> reg_rd_data == $past(conv_data, 2))
        else $error("battery reading not at its offset");

    AST_SHARED_GATED: assert property (
        conv_valid && chan == gsr_pkg::gsr_ch_remote_two &&
        !remote_two_mode |=> rd_r[3] == $past(rd_r[3]))
        else $error("remote two stored while in input mode");

    AST_SUPPLY_SLOT: assert property (
        s_minus_then_read |=> reg_rd_data == $past(conv_data, 2))
        else $error("negative rail reading not at its offset");

    AST_NEWEST: assert property (
        conv_valid && chan == gsr_pkg::gsr_ch_ain_zero
        |=> rd_r[10] == $past(conv_data))
        else $error("reading not refreshed with newest result");

    AST_RESET_STATUS: assert property (
        !$past(resetn) |-> pif.status == `GSR_RST_PIN_STATUS &&
                           !reg_rd_valid)
        else $error("status not cleared by reset");

    AST_RESET_READINGS: assert property (
        !$past(resetn) |-> rd_all_zero &&
                           reg_rd_data == `GSR_RST_READING)
        else $error("readings not cleared by reset");

    AST_RD_ANSWER: assert property (
        reg_rd_en |=> reg_rd_valid)
        else $error("read request got no answer");

    AST_RD_ONCE: assert property (
        !reg_rd_en |=> !reg_rd_valid)
        else $error("answer strobe without a request");

    AST_UNMAPPED: assert property (
        reg_rd_en && !hit_status && !is_reading(reg_addr)
        |=> reg_rd_data == `GSR_UNMAPPED_DATA)
        else $error("unmapped offset did not read zero");

    AST_NINE_STORED: assert property (
        s_nine_result ##0 !remote_two_mode
        |=> rd_r[3] == $past(conv_data))
        else $error("input nine not stored in shared slot");

    AST_NINE_GATED: assert property (
        s_nine_result ##0 remote_two_mode
        |=> rd_r[3] == $past(rd_r[3]))
        else $error("input nine stored while in remote mode");

    AST_BAD_CODE: assert property (
        conv_valid && conv_chan > 4'hB
        |=> rd_r[0] == $past(rd_r[0]))
        else $error("unknown channel code changed a reading");

    AST_OUT_HOLD: assert property (
        pin_dir_out[2] && !(reg_wr_en && hit_status)
        |=> pif.status[2] == $past(pif.status[2]))
        else $error("output status bit changed without a write");

    AST_OE_FOLLOW: assert property (
        $past(resetn) |-> general_io_pin_oe == $past(pin_dir_out))
        else $error("drive enable does not follow direction");

    AST_PIN_LEVEL: assert property (
        $past(resetn) |-> general_io_pin_out ==
            ~($past(pif.status) ^ $past(pif.act_high)))
        else $error("pad level does not match status bit");

endmodule

// File: tb/gsr_reading_regs_tb_top.sv
`timescale 1ns/10ps

// Self-checking bench for the pin status and reading register bank
module gsr_reading_regs_tb_top;

    logic       clk             = 1'b0;  // 250 MHz device clock
    logic       resetn          = 1'b0;  // Synchronous reset, low active
    logic [7:0] reg_addr        = 8'h00; // Register offset
    logic       reg_wr_en       = 1'b0;  // Write strobe
    logic [7:0] reg_wr_data     = 8'h00; // Write byte
    logic       reg_rd_en       = 1'b0;  // Read strobe
    logic [7:0] reg_rd_data;             // Read byte
    logic       reg_rd_valid;            // Read answer pulse
    logic [7:0] pin_dir_out     = 8'h00; // Per pin, 1 = output
    logic [7:0] pin_cfg_three   = 8'hFF; // Active high for pins 8..11
    logic [7:0] pin_cfg_four    = 8'hFF; // Active high for pins 12..15
    logic       remote_two_mode = 1'b0;  // Shared slot selector
    logic       conv_valid      = 1'b0;  // Conversion strobe
    logic [3:0] conv_chan       = 4'h0;  // Conversion channel code
    logic [7:0] conv_data       = 8'h00; // Conversion result
    logic [7:0] pin_in          = 8'h00; // Pad inputs
    logic [7:0] pin_out;                 // Pad drive levels
    logic [7:0] pin_oe;                  // Pad drive enables

    logic [7:0] exp_q[$];       // Expected read bytes, oldest first
    logic [7:0] read_model[11]; // Expected reading slots
    logic [7:0] stat_exp;       // Expected pin status byte
    logic [7:0] exp_v;          // Note taken off the queue
    int         err_total       = 0;
    int         samples_checked = 0;
    int         cycle_cnt       = 0;
    int         seed_v;

    // Device under test
    gsr_reading_regs gsr_reading_regs_i (
        .clk               (clk),
        .resetn            (resetn),
        .reg_addr          (reg_addr),
        .reg_wr_en         (reg_wr_en),
        .reg_wr_data       (reg_wr_data),
        .reg_rd_en         (reg_rd_en),
        .reg_rd_data       (reg_rd_data),
        .reg_rd_valid      (reg_rd_valid),
        .pin_dir_out       (pin_dir_out),
        .pin_cfg_three     (pin_cfg_three),
        .pin_cfg_four      (pin_cfg_four),
        .remote_two_mode   (remote_two_mode),
        .conv_valid        (conv_valid),
        .conv_chan         (conv_chan),
        .conv_data         (conv_data),
        .general_io_pin_in (pin_in),
        .general_io_pin_out(pin_out),
        .general_io_pin_oe (pin_oe)
    );

    // Free running clock
    always #2 clk = ~clk;

    // Verdict in one place only
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compare one byte and count it
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Hang guard, generous against a few hundred cycles of traffic
    always @(posedge clk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end

    // Answer watcher, sampled mid-cycle so edge updates have landed
    always @(negedge clk) begin
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[FAIL] %0t answer without request", $time);
            end else begin
                exp_v = exp_q.pop_front();
                cmp(reg_rd_data, exp_v, "read data");
            end
        end
    end

    // Polarity per pin from the odd bits of both config bytes
    function automatic logic [7:0] act_of(input logic [7:0] c3,
                                          input logic [7:0] c4);
        logic [7:0] a;
        for (int i = 0; i < 4; i++) begin
            a[i]     = c3[2*i+1];
            a[i + 4] = c4[2*i+1];
        end
        return a;
    endfunction

    // One read; a gap cycle follows so the strobe is never retoggled
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        exp_q.push_back(e);
        @(posedge clk); #1;
        reg_rd_en = 1'b0;
        @(posedge clk); #1;
    endtask

    // One write, same spacing as a read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = 1'b1;
        @(posedge clk); #1;
        reg_wr_en   = 1'b0;
        @(posedge clk); #1;
    endtask

    // One conversion result, model updated only when the slot takes it
    task automatic conv(input logic [3:0] ch, input logic [7:0] d);
        int s;
        s = (ch <= 4'h3) ? int'(ch) : int'(ch) - 1;
        conv_chan  = ch;
        conv_data  = d;
        conv_valid = 1'b1;
        if (ch <= 4'hB && !(ch == 4'h3 && !remote_two_mode)
            && !(ch == 4'h4 && remote_two_mode)) begin
            read_model[s] = d;
        end
        @(posedge clk); #1;
        conv_valid = 1'b0;
    endtask

    // Walk the whole map plus two unmapped offsets
    task automatic read_all();
        for (int a = 8'h25; a <= 8'h31; a++) begin
            if (a == 8'h25) begin
                rd(8'h25, stat_exp);
            end else if (a == 8'h31) begin
                rd(8'h31, 8'h00);
            end else begin
                rd(8'(a), read_model[a - 8'h26]);
            end
        end
        rd(8'h00, 8'h00);
    endtask

    // Main sequence
    initial begin
        logic [7:0] wd;
        logic [7:0] act;
        logic [7:0] dl;
        seed_v   = $urandom(78558);
        stat_exp = 8'h00;
        foreach (read_model[i]) read_model[i] = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        read_all();
        // Every channel code in both shared slot modes
        for (int m = 0; m < 2; m++) begin
            remote_two_mode = m[0];
            for (int ch = 0; ch < 16; ch++) begin
                conv(4'(ch), 8'($urandom));
            end
            read_all();
        end
        // Host writes to readings must bounce off
        for (int a = 8'h26; a <= 8'h30; a++) begin
            wr(8'(a), 8'($urandom));
        end
        read_all();
        // Result then an immediate read of the same slot
        conv(4'h0, 8'($urandom));
        rd(8'h26, read_model[0]);
        conv(4'hA, 8'($urandom));
        rd(8'h2F, read_model[9]);
        // Pins with random direction, polarity and levels
        repeat (8) begin
            pin_dir_out   = 8'($urandom);
            pin_cfg_three = 8'($urandom);
            pin_cfg_four  = 8'($urandom);
            pin_in        = 8'($urandom);
            wd            = 8'($urandom);
            act           = act_of(pin_cfg_three, pin_cfg_four);
            repeat (4) @(posedge clk);
            #1;
            wr(8'h25, wd);
            @(posedge clk); #1;
            cmp(pin_oe, pin_dir_out, "drive enable");
            dl = ~(wd ^ act) & pin_dir_out;
            cmp(pin_out & pin_dir_out, dl, "level");
            stat_exp = (wd & pin_dir_out) | (~pin_dir_out & ~(pin_in ^ act));
            rd(8'h25, stat_exp);
        end
        // Second reset in mid run with every pin idle
        pin_dir_out = 8'h00;
        pin_in      = ~act_of(pin_cfg_three, pin_cfg_four);
        resetn      = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn   = 1'b1;
        stat_exp = 8'h00;
        cmp(pin_oe, 8'h00, "drive enable after reset");
        foreach (read_model[i]) read_model[i] = 8'h00;
        read_all();
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            err_total++;
            $display("[FAIL] %0t reads left unanswered", $time);
        end
        final_report();
    end

endmodule
